// [hdl/elss_pkg.sv]
// Package with shared constants and carrier types for lane and state steering.
`default_nettype none
package elss_pkg;

   // ----------------------------------------------------------------
   // Access sizes and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_HALF = 2'h1,
      SIZE_WORD = 2'h2
   } elss_size_type;

   typedef enum logic [1:0] {
      ST_NATIVE = 2'h1,
      ST_COMPRESSED = 2'h2
   } elss_state_type;

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int LANE_W = 8;
   localparam int LANES = 4;
   localparam int PTR_SEL_BIT = 1;
   localparam logic RESET_BIG_ENDIAN = 1'b0;
   localparam logic [31:0] RESET_POINTER = 32'h0000_0000;
   localparam logic [31:0] NATIVE_STEP = 32'h0000_0004;
   localparam logic [31:0] COMPRESSED_STEP = 32'h0000_0002;

   // Data request from the core towards memory.
   typedef struct packed {
      logic write;
      elss_size_type size;
      logic sign_ext;
      logic [31:0] addr;
      logic [31:0] wdata;
   } elss_req_type;

   // Lane-steered request as seen by the memory system.
   typedef struct packed {
      logic write;
      logic [3:0] lane_en;
      logic [31:0] addr;
      logic [31:0] wdata;
   } elss_bus_type;

endpackage
`default_nettype wire

// [hdl/elss_lane_map.sv]
// Combinational byte-lane mapping for either endian configuration.
`timescale 1ns/10ps
`default_nettype none
module elss_lane_map (
   // Access description
   input wire logic i_big_endian,
   input wire elss_pkg::elss_size_type i_size,
   input wire logic [1:0] i_addr_lo,
   // Lane enables
   output logic [3:0] o_lane_en
);

   // ----------------------------------------------------------------
   // Lane selection
   // ----------------------------------------------------------------

   // Returns the physical lane of a byte offset within a word.
   function automatic logic [1:0] lane_of(input logic be,
                                           input logic [1:0] off);
      lane_of = be ? ~off : off;
   endfunction

   // Enables one, two or four lanes depending on size.
   always_comb begin
      o_lane_en = 4'h0;
      case (i_size)
         elss_pkg::SIZE_BYTE: begin
            o_lane_en[lane_of(i_big_endian, i_addr_lo)] = 1'b1;
         end
         elss_pkg::SIZE_HALF: begin
            o_lane_en[lane_of(i_big_endian, {i_addr_lo[1], 1'b0})] = 1'b1;
            o_lane_en[lane_of(i_big_endian, {i_addr_lo[1], 1'b1})] = 1'b1;
         end
         elss_pkg::SIZE_WORD: begin
            o_lane_en = 4'hF;
         end
         default: begin
            o_lane_en = 4'h0;
         end
      endcase
   end

endmodule
`default_nettype wire

// [hdl/elss_load_ext.sv]
// Combinational load lane extraction with zero or sign extension.
`timescale 1ns/10ps
`default_nettype none
module elss_load_ext (
   // Access description
   input wire logic i_big_endian,
   input wire elss_pkg::elss_size_type i_size,
   input wire logic i_sign_ext,
   input wire logic [1:0] i_addr_lo,
   input wire logic [31:0] i_rdata,
   // Result
   output logic [31:0] o_value
);

   // ----------------------------------------------------------------
   // Extraction
   // ----------------------------------------------------------------
   logic [7:0] byte_val;
   logic [15:0] half_val;
   logic [1:0] blane;

   // Picks the lane holding the addressed byte or halfword.
   always_comb begin
      blane = i_big_endian ? ~i_addr_lo : i_addr_lo;
      byte_val = i_rdata[blane*8 +: 8];
      if (i_big_endian ^ i_addr_lo[1]) begin
         half_val = i_rdata[31:16];
      end else begin
         half_val = i_rdata[15:0];
      end
      case (i_size)
         elss_pkg::SIZE_BYTE: begin
            o_value = {{24{i_sign_ext & byte_val[7]}}, byte_val};
         end
         elss_pkg::SIZE_HALF: begin
            o_value = {{16{i_sign_ext & half_val[15]}}, half_val};
         end
         default: begin
            o_value = i_rdata;
         end
      endcase
   end

endmodule
`default_nettype wire

// [hdl/elss_top.sv]
// Endian lane steering and execution state control of a 32-bit core.
// ----------------------------------------------------------------
// Notes on behaviour
// - Little-endian: byte at word address on bits 7..0, upward lanes.
// - Big-endian: byte at word address on bits 31..24, downward lanes.
// - Little-endian: low address least significant; halfword zero low.
// - Big-endian: low address most significant; halfword zero high.
// - Memory is bytes numbered from zero, four to a word.
// - Word, halfword and byte transfer sizes are supported.
// - Native state fetches words; compressed state fetches halfwords.
// - Compressed state uses pointer bit 1 to pick the halfword.
// - State switch leaves mode and registers unchanged.
// - Exchange branch switches state, target from low or high register.
// - Exceptions enter native state; return restores the state saved at entry.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module elss_top (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_clk_en,
   // Configuration pin
   input wire logic i_big_endian,
   // Data request from the core
   input wire logic i_req_valid,
   input wire elss_pkg::elss_req_type i_req,
   // Data bus to memory
   output logic o_bus_valid,
   output elss_pkg::elss_bus_type o_bus,
   output logic o_align_err,
   // Read return from memory
   input wire logic i_rd_valid,
   input wire logic [31:0] i_rdata,
   output logic o_load_valid,
   output logic [31:0] o_load_value,
   // Instruction fetch
   input wire logic i_fetch_adv,
   input wire logic [31:0] i_fetch_word,
   output logic [31:0] o_fetch_addr,
   output logic [31:0] o_instr,
   output logic o_instr_wide,
   // State control
   input wire logic i_xbranch,
   input wire logic [31:0] i_xbranch_target,
   input wire logic i_exc_take,
   input wire logic [31:0] i_exc_vector,
   input wire logic i_exc_return,
   input wire logic [31:0] i_exc_ret_addr,
   output logic o_compressed,
   output logic o_saved_compressed
);

   // ----------------------------------------------------------------
   // Configuration pin synchroniser
   // ----------------------------------------------------------------
   logic be_meta;
   logic be_sync;

   // Two stages before the endian setting is used.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         be_meta <= elss_pkg::RESET_BIG_ENDIAN;
         be_sync <= elss_pkg::RESET_BIG_ENDIAN;
      end else if (i_clk_en) begin
         be_meta <= i_big_endian;
         be_sync <= be_meta;
      end
   end

   // ----------------------------------------------------------------
   // Store and request steering
   // ----------------------------------------------------------------
   logic [3:0] lane_en;
   logic [31:0] next_wdata;
   logic next_misaligned;
   logic [1:0] req_off;
   elss_pkg::elss_req_type load_req;

   assign req_off = i_req.addr[1:0];

   elss_lane_map u_lane_map (
      .i_big_endian(be_sync),
      .i_size(i_req.size),
      .i_addr_lo(req_off),
      .o_lane_en(lane_en)
   );

   // Replicates narrow store data onto every lane it may occupy.
   always_comb begin
      case (i_req.size)
         elss_pkg::SIZE_BYTE: next_wdata = {4{i_req.wdata[7:0]}};
         elss_pkg::SIZE_HALF: next_wdata = {2{i_req.wdata[15:0]}};
         default: next_wdata = i_req.wdata;
      endcase
   end

   // Flags addresses that break natural alignment.
   always_comb begin
      case (i_req.size)
         elss_pkg::SIZE_WORD: next_misaligned = |req_off;
         elss_pkg::SIZE_HALF: next_misaligned = req_off[0];
         default: next_misaligned = 1'b0;
      endcase
   end

   // Registers the steered request; lanes tell memory what to keep.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_bus_valid <= 1'b0;
         o_bus <= '0;
         o_align_err <= 1'b0;
         load_req <= '0;
      end else if (i_clk_en) begin
         o_bus_valid <= i_req_valid;
         o_align_err <= i_req_valid & next_misaligned;
         if (i_req_valid) begin
            o_bus.write <= i_req.write;
            o_bus.lane_en <= lane_en;
            o_bus.addr <= i_req.addr;
            o_bus.wdata <= next_wdata;
            load_req <= i_req;
         end
      end
   end

   // ----------------------------------------------------------------
   // Load return
   // ----------------------------------------------------------------
   logic [31:0] next_load;

   elss_load_ext u_load_ext (
      .i_big_endian(be_sync),
      .i_size(load_req.size),
      .i_sign_ext(load_req.sign_ext),
      .i_addr_lo(load_req.addr[1:0]),
      .i_rdata(i_rdata),
      .o_value(next_load)
   );

   // Captures the extended load result one cycle after return.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_load_valid <= 1'b0;
         o_load_value <= 32'h0000_0000;
      end else if (i_clk_en) begin
         o_load_valid <= i_rd_valid;
         if (i_rd_valid) begin
            o_load_value <= next_load;
         end
      end
   end

   // ----------------------------------------------------------------
   // Execution state machine
   // ----------------------------------------------------------------
   elss_pkg::elss_state_type state;
   elss_pkg::elss_state_type next_state;
   logic saved_cmp;

   // Exceptions win over a branch in the same cycle.
   always_comb begin
      case (state)
         elss_pkg::ST_NATIVE, elss_pkg::ST_COMPRESSED: begin
            if (i_exc_take) begin
               next_state = elss_pkg::ST_NATIVE;
            end else if (i_exc_return) begin
               next_state = saved_cmp ? elss_pkg::ST_COMPRESSED
                                      : elss_pkg::ST_NATIVE;
            end else if (i_xbranch) begin
               next_state = i_xbranch_target[0] ? elss_pkg::ST_COMPRESSED
                                                : elss_pkg::ST_NATIVE;
            end else begin
               next_state = state;
            end
         end
         default: next_state = elss_pkg::ST_NATIVE;
      endcase
   end

   // Only the state bit changes; mode and registers live elsewhere.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= elss_pkg::ST_NATIVE;
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   // Remembers the state interrupted by an exception.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         saved_cmp <= 1'b0;
      end else if (i_clk_en && i_exc_take) begin
         saved_cmp <= (state == elss_pkg::ST_COMPRESSED);
      end
   end

   assign o_compressed = (state == elss_pkg::ST_COMPRESSED);
   assign o_saved_compressed = saved_cmp;

   // ----------------------------------------------------------------
   // Instruction pointer and fetch
   // ----------------------------------------------------------------
   logic [31:0] instruction_pointer;
   logic [31:0] next_pointer;

   // Aligns redirects to the width of the state being entered.
   function automatic logic [31:0] align_ptr(input logic [31:0] a,
                                             input logic cmp);
      align_ptr = cmp ? {a[31:1], 1'b0} : {a[31:2], 2'h0};
   endfunction

   // Chooses the next pointer from redirects or sequential step.
   always_comb begin
      if (i_exc_take) begin
         next_pointer = align_ptr(i_exc_vector, 1'b0);
      end else if (i_exc_return) begin
         next_pointer = align_ptr(i_exc_ret_addr, saved_cmp);
      end else if (i_xbranch) begin
         next_pointer = align_ptr(i_xbranch_target, i_xbranch_target[0]);
      end else if (i_fetch_adv) begin
         next_pointer = instruction_pointer + (o_compressed
            ? elss_pkg::COMPRESSED_STEP : elss_pkg::NATIVE_STEP);
      end else begin
         next_pointer = instruction_pointer;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         instruction_pointer <= elss_pkg::RESET_POINTER;
      end else if (i_clk_en) begin
         instruction_pointer <= next_pointer;
      end
   end

   assign o_fetch_addr = {instruction_pointer[31:2], 2'h0};

   // Picks the current instruction out of the fetched word.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_instr <= 32'h0000_0000;
         o_instr_wide <= 1'b1;
      end else if (i_clk_en) begin
         o_instr_wide <= !o_compressed;
         if (!o_compressed) begin
            o_instr <= i_fetch_word;
         end else if (instruction_pointer[elss_pkg::PTR_SEL_BIT] ^ be_sync)
         begin
            o_instr <= {16'h0000, i_fetch_word[31:16]};
         end else begin
            o_instr <= {16'h0000, i_fetch_word[15:0]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_exc_native: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_exc_take |=> !o_compressed)
      else $error("Exception entry did not select native state.");

   a_exc_restore: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_exc_return && !i_exc_take
      |=> o_compressed == $past(o_saved_compressed))
      else $error("Return did not restore the saved state.");

   a_xbranch_state: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_xbranch && !i_exc_take && !i_exc_return
      |=> o_compressed == $past(i_xbranch_target[0]))
      else $error("Exchange branch chose the wrong state.");

   a_word_lanes: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_req_valid && i_req.size == elss_pkg::SIZE_WORD
      |=> o_bus.lane_en == 4'hF)
      else $error("Word access did not enable all lanes.");

   a_byte_lane: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_req_valid && i_req.size == elss_pkg::SIZE_BYTE
      && i_req.addr[1:0] == 2'h0
      |=> o_bus.lane_en == ($past(be_sync) ? 4'h8 : 4'h1))
      else $error("Byte zero steered to wrong lane.");

   a_align_flag: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_req_valid && i_req.size == elss_pkg::SIZE_HALF
      && i_req.addr[0] |=> o_align_err)
      else $error("Odd halfword address not flagged.");

   a_ptr_aligned: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      !o_compressed |-> instruction_pointer[1:0] == 2'h0)
      else $error("Native pointer not word aligned.");

   a_load_sext: assert property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_clk_en && i_rd_valid && load_req.size == elss_pkg::SIZE_BYTE
      && load_req.sign_ext |=> o_load_value[31:8] == {24{o_load_value[7]}})
      else $error("Signed byte load not sign extended.");

   c_exc_from_cmp: cover property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      o_compressed && i_exc_take);
   c_half_store: cover property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_req_valid && i_req.write && i_req.size == elss_pkg::SIZE_HALF);
   c_big_load: cover property (
      @(posedge i_clk_sys) disable iff (!i_arst_n)
      be_sync && i_rd_valid);

endmodule
`default_nettype wire

// [testbench/elss_mem_model.sv]
// Behavioural memory system that serves steered byte, halfword, word traffic.
`timescale 1ns/10ps
`default_nettype none
module elss_mem_model (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   // Extra wait cycles before a read answer
   input wire logic [1:0] i_wait,
   // Steered bus from the core
   input wire logic i_bus_valid,
   input wire elss_pkg::elss_bus_type i_bus,
   // Read return
   output logic o_rd_valid,
   output logic [31:0] o_rdata
);
   // ----------------------------------------------------------------
   // Storage and read sequencing
   // ----------------------------------------------------------------
   logic [31:0] mem [0:15];
   logic [3:0] idx;
   logic [1:0] cnt;
   logic pend;

   // Only enabled lanes are written, so neighbouring bytes survive.
   always @(posedge i_clk_sys) begin
      if (i_bus_valid && i_bus.write) begin
         for (int l = 0; l < 4; l++) begin
            if (i_bus.lane_en[l]) begin
               mem[i_bus.addr[5:2]][8*l +: 8] <= i_bus.wdata[8*l +: 8];
            end
         end
      end
   end

   // Reads of every size return the whole word after the chosen delay.
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pend <= 1'h0;
         cnt <= 2'h0;
         idx <= 4'h0;
         o_rd_valid <= 1'h0;
         o_rdata <= 32'h0;
      end else begin
         o_rd_valid <= 1'h0;
         o_rdata <= ~o_rdata; // Idle data keeps moving so it cannot pass.
         if (i_bus_valid && !i_bus.write) begin
            pend <= 1'h1;
            cnt <= i_wait;
            idx <= i_bus.addr[5:2];
         end else if (pend && cnt == 2'h0) begin
            pend <= 1'h0;
            o_rd_valid <= 1'h1;
            o_rdata <= mem[idx];
         end else if (pend) begin
            cnt <= cnt - 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/test_elss_top.sv]
// Self-checking bench for lane steering and execution state control.
`timescale 1ns/10ps
`default_nettype none
module test_elss_top;
   // ----------------------------------------------------------------
   // Signals, clock and instances
   // ----------------------------------------------------------------
   logic i_clk_sys = 1'h0;
   logic i_arst_n = 1'h0;
   logic i_clk_en = 1'h1;
   logic i_big_endian = 1'h0;
   logic i_req_valid = 1'h0;
   elss_pkg::elss_req_type i_req = '0;
   logic [1:0] mem_wait = 2'h0;
   logic i_fetch_adv = 1'h0;
   logic [31:0] i_fetch_word = 32'hCAFE_BEEF;
   logic i_xbranch = 1'h0;
   logic [31:0] i_xbranch_target = 32'h0;
   logic i_exc_take = 1'h0;
   logic [31:0] i_exc_vector = 32'h0;
   logic i_exc_return = 1'h0;
   logic [31:0] i_exc_ret_addr = 32'h0;
   logic rd_valid;
   logic [31:0] rdata;
   logic o_bus_valid;
   elss_pkg::elss_bus_type o_bus;
   logic o_align_err;
   logic o_load_valid;
   logic [31:0] o_load_value;
   logic [31:0] o_fetch_addr;
   logic [31:0] o_instr;
   logic o_instr_wide;
   logic o_compressed;
   logic o_saved_compressed;
   int fails = 0;
   int tests_run = 0;

   // Free-running 100 MHz system clock.
   always #5 i_clk_sys = ~i_clk_sys;

   elss_top u_elss_top (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
      .i_clk_en(i_clk_en), .i_big_endian(i_big_endian),
      .i_req_valid(i_req_valid), .i_req(i_req), .o_bus_valid(o_bus_valid),
      .o_bus(o_bus), .o_align_err(o_align_err), .i_rd_valid(rd_valid),
      .i_rdata(rdata), .o_load_valid(o_load_valid),
      .o_load_value(o_load_value), .i_fetch_adv(i_fetch_adv),
      .i_fetch_word(i_fetch_word), .o_fetch_addr(o_fetch_addr),
      .o_instr(o_instr), .o_instr_wide(o_instr_wide),
      .i_xbranch(i_xbranch), .i_xbranch_target(i_xbranch_target),
      .i_exc_take(i_exc_take), .i_exc_vector(i_exc_vector),
      .i_exc_return(i_exc_return), .i_exc_ret_addr(i_exc_ret_addr),
      .o_compressed(o_compressed), .o_saved_compressed(o_saved_compressed));

   elss_mem_model u_elss_mem_model (.i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n), .i_wait(mem_wait), .i_bus_valid(o_bus_valid),
      .i_bus(o_bus), .o_rd_valid(rd_valid), .o_rdata(rdata));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude;
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Issues one data request and judges the steered bus and any load.
   task automatic access(input logic wr, input elss_pkg::elss_size_type sz,
                         input logic sx, input logic [31:0] a,
                         input logic [31:0] d, input logic [31:0] exp);
      logic [3:0] lanes;
      logic [31:0] wexp;
      logic bad;
      int n;
      lanes = 4'hF;
      wexp = d;
      if (sz == elss_pkg::SIZE_BYTE) begin
         lanes = 4'h1 << (i_big_endian ? 2'h3 - a[1:0] : a[1:0]);
         wexp = {4{d[7:0]}};
      end else if (sz == elss_pkg::SIZE_HALF) begin
         lanes = (a[1] ^ i_big_endian) ? 4'hC : 4'h3;
         wexp = {2{d[15:0]}};
      end
      bad = (sz == elss_pkg::SIZE_WORD && a[1:0] != 2'h0) ||
            (sz == elss_pkg::SIZE_HALF && a[0]);
      @(posedge i_clk_sys);
      i_req_valid <= 1'h1;
      i_req <= '{wr, sz, sx, a, d};
      @(posedge i_clk_sys);
      i_req_valid <= 1'h0;
      #1;
      check("bus valid", o_bus_valid, 32'h1);
      check("align error", o_align_err, {31'h0, bad});
      check("lane enables", o_bus.lane_en, lanes);
      check("bus address", o_bus.addr, a);
      check("bus write", o_bus.write, {31'h0, wr});
      if (wr) begin
         check("write data", o_bus.wdata, wexp);
      end else begin
         n = 0;
         while (o_load_valid !== 1'h1 && n < 20) begin
            @(posedge i_clk_sys);
            #1;
            n++;
         end
         check("load valid", o_load_valid, 32'h1);
         check("load value", o_load_value, exp);
      end
   endtask

   // Lowers every state event pulse at the next edge, then settles.
   task automatic tick;
      @(posedge i_clk_sys);
      i_xbranch <= 1'h0;
      i_exc_take <= 1'h0;
      i_exc_return <= 1'h0;
      i_fetch_adv <= 1'h0;
      #1;
   endtask

   // Raises one state event: 0 branch, 1 entry, 2 return, 3 advance.
   task automatic ev(input int kind, input logic [31:0] v);
      @(posedge i_clk_sys);
      case (kind)
         0: begin
            i_xbranch <= 1'h1;
            i_xbranch_target <= v;
         end
         1: begin
            i_exc_take <= 1'h1;
            i_exc_vector <= v;
         end
         2: begin
            i_exc_return <= 1'h1;
            i_exc_ret_addr <= v;
         end
         default: i_fetch_adv <= 1'h1;
      endcase
      tick();
   endtask

   // Sets the endian pin and lets its two-stage sampling settle.
   task automatic set_endian(input logic be);
      @(posedge i_clk_sys);
      i_big_endian <= be;
      repeat (3) @(posedge i_clk_sys);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Narrow stores into the second word, then loads of every size.
   task automatic t_endian(input logic be, input logic [1:0] w);
      mem_wait <= w;
      set_endian(be);
      for (int i = 0; i < 4; i++) begin
         access(1'h1, elss_pkg::SIZE_BYTE, 1'h0, 32'h4 + 32'(i),
                32'(32'h11 * (i + 1)), 32'h0);
      end
      access(1'h1, elss_pkg::SIZE_HALF, 1'h0, 32'h6, 32'hA5B6, 32'h0);
      access(1'h0, elss_pkg::SIZE_WORD, 1'h0, 32'h4, 32'h0,
             be ? 32'h1122_A5B6 : 32'hA5B6_2211);
      access(1'h0, elss_pkg::SIZE_HALF, 1'h0, 32'h4, 32'h0,
             be ? 32'h1122 : 32'h2211);
      access(1'h0, elss_pkg::SIZE_BYTE, 1'h1, 32'h6, 32'h0,
             be ? 32'hFFFF_FFA5 : 32'hFFFF_FFB6);
      access(1'h0, elss_pkg::SIZE_BYTE, 1'h0, 32'h7, 32'h0,
             be ? 32'h0000_00B6 : 32'h0000_00A5);
      access(1'h0, elss_pkg::SIZE_HALF, 1'h1, 32'h6, 32'h0,
             32'hFFFF_A5B6);
      access(1'h1, elss_pkg::SIZE_WORD, 1'h0, 32'h8, 32'h8765_4321,
             32'h0);
   endtask

   // Misaligned and boundary addresses are still issued; only the misaligned ones raise the flag.
   task automatic t_misalign;
      access(1'h1, elss_pkg::SIZE_WORD, 1'h0, 32'h5, 32'h1, 32'h0);
      access(1'h1, elss_pkg::SIZE_HALF, 1'h0, 32'h3, 32'h2, 32'h0);
      access(1'h1, elss_pkg::SIZE_HALF, 1'h0, 32'h2, 32'h3, 32'h0);
      access(1'h1, elss_pkg::SIZE_BYTE, 1'h0, 32'h3, 32'h4, 32'h0);
   endtask

   // State switching, halfword choice, exception entry and return.
   task automatic t_state;
      logic [31:0] held;
      set_endian(1'h0);
      held = o_load_value;
      ev(0, 32'h0000_0101);
      check("to compressed", o_compressed, 32'h1);
      check("half fetch addr", o_fetch_addr, 32'h100);
      @(posedge i_clk_sys);
      #1;
      check("lower half", o_instr, 32'h0000_BEEF);
      check("narrow instr", o_instr_wide, 32'h0);
      ev(3, 32'h0);
      @(posedge i_clk_sys);
      #1;
      check("upper half", o_instr, 32'h0000_CAFE);
      ev(1, 32'h18);
      check("entry native", o_compressed, 32'h0);
      check("saved state", o_saved_compressed, 32'h1);
      check("vector addr", o_fetch_addr, 32'h18);
      @(posedge i_clk_sys);
      #1;
      check("wide instr", o_instr, 32'hCAFE_BEEF);
      check("wide flag", o_instr_wide, 32'h1);
      ev(0, 32'h41);
      ev(0, 32'h18);
      check("handler back", o_compressed, 32'h0);
      ev(2, 32'h102);
      check("return state", o_compressed, 32'h1);
      check("return addr", o_fetch_addr, 32'h100);
      ev(0, 32'h200);
      check("to native", o_compressed, 32'h0);
      ev(3, 32'h0);
      check("word step", o_fetch_addr, 32'h204);
      @(posedge i_clk_sys);
      i_clk_en <= 1'h0;
      ev(0, 32'h301);
      check("frozen state", o_compressed, 32'h0);
      @(posedge i_clk_sys);
      i_clk_en <= 1'h1;
      #1;
      check("load kept", o_load_value, held);
      set_endian(1'h1);
      ev(0, 32'h101);
      @(posedge i_clk_sys);
      #1;
      check("big upper half", o_instr, 32'h0000_CAFE);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   // Holds reset, then runs every scenario in turn.
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_arst_n <= 1'h1;
      @(posedge i_clk_sys);
      #1;
      check("reset wide", o_instr_wide, 32'h1);
      check("reset state", o_compressed, 32'h0);
      t_endian(1'h0, 2'h0);
      t_endian(1'h1, 2'h3);
      t_misalign();
      t_state();
      conclude();
   end

   // Cuts a hang short well beyond the hundred and fifty or so cycles expected.
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
